// ---- design/cbhd_defines.svh ----
`ifndef CBHD_DEFINES_SVH
`define CBHD_DEFINES_SVH

// Operation codes in the low bits of byte 0; the legacy code is the whole byte
`define CBHD_OP_INIT 3'h0
`define CBHD_OP_TGT 3'h1
`define CBHD_OP_INIT_SG 3'h2
`define CBHD_OP_INIT_RES 3'h3
`define CBHD_OP_SG_RES 3'h4
`define CBHD_OP_LEGACY_RST 8'h81

// Byte 0 field positions
`define CBHD_B0_RST 7
`define CBHD_B0_HOLD 6
`define CBHD_B0_NORETRY 5
`define CBHD_B0_OP_HI 2

// Byte 1 field positions
`define CBHD_B1_ID_HI 7
`define CBHD_B1_ID_LO 5
`define CBHD_B1_OUT 4
`define CBHD_B1_IN 3
`define CBHD_B1_LUN_HI 2

// Adapter status codes
`define CBHD_HS_OK 8'h00
`define CBHD_HS_OVERRUN 8'h12
`define CBHD_HS_BAD_OP 8'h16
`define CBHD_HS_BAD_PARAM 8'h18
`define CBHD_HS_BYTE 14

// Target status codes
`define CBHD_TS_GOOD 8'h00
`define CBHD_TS_BUSY 8'h08

// Busy retry delay
`define CBHD_CLK_HZ 50000000
`define CBHD_RETRY_MS 700
`define CBHD_RETRY_CYC ((`CBHD_CLK_HZ / 1000) * `CBHD_RETRY_MS)

`endif

// ---- design/cbhd_pkg.sv ----
package cbhd_pkg;

   // Decoder sequence, one-hot
   typedef enum logic [4:0] {
      CBHD_IDLE = 5'h01,
      CBHD_EXEC = 5'h02,
      CBHD_WAIT = 5'h04,
      CBHD_RETRY = 5'h08,
      CBHD_DONE = 5'h10
   } cbhd_state_t;

   // Dispatched action
   typedef enum logic [2:0] {
      CBHD_ACT_NONE = 3'h0,
      CBHD_ACT_INIT = 3'h1,
      CBHD_ACT_SG = 3'h2,
      CBHD_ACT_TGT = 3'h3,
      CBHD_ACT_DEVRST = 3'h4,
      CBHD_ACT_ABORT_RST = 3'h5
   } cbhd_act_t;

   typedef struct packed {
      cbhd_state_t st;
      cbhd_act_t act;
      logic [31:0] wait_cnt;
      logic no_retry;
      logic exec_start;
      logic hold_conn;
      logic residual;
      logic [2:0] dev_id;
      logic [2:0] lun;
      logic dir_in;
      logic dir_out;
      logic len_check;
      logic no_xfer;
      logic [7:0] cdb_len;
      logic done;
      logic [7:0] adapter_status;
      logic [7:0] target_status;
      logic [7:0] status_index;
      logic busy;
   } cbhd_regs_t;

endpackage

// ---- design/cbhd_decoder.sv ----
// Behaviour
// - Operation codes 00h to 04h are accepted as valid.
// - No-retry clear retries busy; set reports busy in target status byte.
// - Wait about 700 ms between busy retries; no new block is taken until this one completes.
// - Hold flag forbids disconnection if target allows it; else per-target config.
// - Device reset flag sends bus device reset to target, other flags ignored.
// - Codes 00h and 03h execute the descriptor; 03h returns residual length.
// - Code 01h services target mode; without target mode status is 18h.
// - Codes 02h and 04h execute with a scatter/gather segment list.
// - Legacy code 81h aborts target tasks and sends bus device reset.
// - Any other code completes the block with status 16h.
// - Address bits 7-5 name target, or initiator for a target block.
// - Target block with direction bits equal completes with status 18h.
// - Initiator direction comes from the command; both bits set means no transfer.
// - Only bit 3 set means inbound transfer from the SCSI device.
// - Either direction bit on initiator checks length; overrun gives status 12h.
// - Both bits clear: media over/underrun completes without error.
// - Address bits 2-0 are the LUN placed in the identify message.
// - Byte 2 is the command descriptor length in bytes.
// - The whole first byte is also compared with the one legacy opcode, 81h.
// - Completion and error codes go to command block byte 14.
`timescale 1ns/1ns
`include "cbhd_defines.svh"

module cbhd_decoder #(
   parameter int unsigned RETRY_CYCLES = `CBHD_RETRY_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_byte0,
   input wire logic [7:0] hdr_byte1,
   input wire logic [7:0] hdr_byte2,
   input wire logic target_mode_en,
   input wire logic disc_enabled,
   input wire logic exec_done,
   input wire logic exec_busy,
   input wire logic exec_overrun,
   input wire logic exec_media,
   input wire logic [7:0] exec_tstatus,
   output logic busy,
   output logic exec_start,
   output cbhd_pkg::cbhd_act_t exec_action,
   output logic allow_disconnect,
   output logic residual_mode,
   output logic [2:0] dev_id,
   output logic [2:0] lun,
   output logic dir_in,
   output logic dir_out,
   output logic no_xfer,
   output logic [7:0] cdb_len,
   output logic done,
   output logic [7:0] status_index,
   output logic [7:0] adapter_status,
   output logic [7:0] target_status
);

   cbhd_pkg::cbhd_regs_t s_r;
   cbhd_pkg::cbhd_regs_t s_nxt;
   logic [2:0] op;
   logic legacy_rst;

   assign op = hdr_byte0[`CBHD_B0_OP_HI:0];
   assign legacy_rst = (hdr_byte0 == `CBHD_OP_LEGACY_RST);

   // Decode, dispatch and completion
   always_comb begin
      s_nxt = s_r;
      s_nxt.exec_start = 1'b0;
      s_nxt.done = 1'b0;
      unique case (s_r.st)
         cbhd_pkg::CBHD_IDLE: begin
            if (hdr_valid) begin
               s_nxt.busy = 1'b1;
               s_nxt.dev_id = hdr_byte1[`CBHD_B1_ID_HI:`CBHD_B1_ID_LO];
               s_nxt.lun = hdr_byte1[`CBHD_B1_LUN_HI:0];
               s_nxt.dir_in = hdr_byte1[`CBHD_B1_IN];
               s_nxt.dir_out = hdr_byte1[`CBHD_B1_OUT];
               s_nxt.cdb_len = hdr_byte2;
               s_nxt.no_retry = hdr_byte0[`CBHD_B0_NORETRY];
               s_nxt.hold_conn = hdr_byte0[`CBHD_B0_HOLD];
               s_nxt.residual = 1'b0;
               s_nxt.len_check = 1'b0;
               s_nxt.no_xfer = 1'b0;
               s_nxt.adapter_status = `CBHD_HS_OK;
               s_nxt.target_status = `CBHD_TS_GOOD;
               s_nxt.status_index = 8'(`CBHD_HS_BYTE);
               s_nxt.st = cbhd_pkg::CBHD_EXEC;
               s_nxt.exec_start = 1'b1;
               if (legacy_rst) begin
                  s_nxt.act = cbhd_pkg::CBHD_ACT_ABORT_RST;
                  s_nxt.hold_conn = 1'b0;
                  s_nxt.no_retry = 1'b1;
               end else if (hdr_byte0[`CBHD_B0_RST]) begin
                  s_nxt.act = cbhd_pkg::CBHD_ACT_DEVRST;
                  s_nxt.hold_conn = 1'b0;
                  s_nxt.no_retry = 1'b1;
               end else if (hdr_byte0[4:3] != 2'h0 || op > `CBHD_OP_SG_RES) begin
                  // Reserved bits set also make the opcode invalid
                  s_nxt.act = cbhd_pkg::CBHD_ACT_NONE;
                  s_nxt.adapter_status = `CBHD_HS_BAD_OP;
                  s_nxt.exec_start = 1'b0;
                  s_nxt.st = cbhd_pkg::CBHD_DONE;
               end else if (op == `CBHD_OP_TGT) begin
                  s_nxt.act = cbhd_pkg::CBHD_ACT_TGT;
                  if (!target_mode_en ||
                      hdr_byte1[`CBHD_B1_IN] == hdr_byte1[`CBHD_B1_OUT]) begin
                     s_nxt.adapter_status = `CBHD_HS_BAD_PARAM;
                     s_nxt.exec_start = 1'b0;
                     s_nxt.st = cbhd_pkg::CBHD_DONE;
                  end
               end else begin
                  // Codes 00h..04h other than target
                  s_nxt.act = (op == `CBHD_OP_INIT_SG || op == `CBHD_OP_SG_RES) ?
                     cbhd_pkg::CBHD_ACT_SG : cbhd_pkg::CBHD_ACT_INIT;
                  s_nxt.residual = (op == `CBHD_OP_INIT_RES || op == `CBHD_OP_SG_RES);
                  s_nxt.len_check = hdr_byte1[`CBHD_B1_IN] | hdr_byte1[`CBHD_B1_OUT];
                  s_nxt.no_xfer = hdr_byte1[`CBHD_B1_IN] & hdr_byte1[`CBHD_B1_OUT];
               end
            end
         end
         cbhd_pkg::CBHD_EXEC: begin
            if (exec_done) begin
               s_nxt.target_status = exec_tstatus;
               if (exec_busy && !s_r.no_retry) begin
                  s_nxt.wait_cnt = 32'(RETRY_CYCLES - 1);
                  s_nxt.st = cbhd_pkg::CBHD_WAIT;
               end else begin
                  // Busy with no-retry falls through and reports it
                  if (exec_overrun && s_r.len_check && !exec_media)
                     s_nxt.adapter_status = `CBHD_HS_OVERRUN;
                  else if (exec_overrun && s_r.len_check)
                     s_nxt.adapter_status = `CBHD_HS_OVERRUN;
                  else
                     s_nxt.adapter_status = `CBHD_HS_OK;
                  s_nxt.st = cbhd_pkg::CBHD_DONE;
               end
            end
         end
         cbhd_pkg::CBHD_WAIT: begin
            // Executor gets no start during the wait; no other block is taken
            if (s_r.wait_cnt == 32'h0)
               s_nxt.st = cbhd_pkg::CBHD_RETRY;
            else
               s_nxt.wait_cnt = s_r.wait_cnt - 32'h1;
         end
         cbhd_pkg::CBHD_RETRY: begin
            s_nxt.exec_start = 1'b1;
            s_nxt.st = cbhd_pkg::CBHD_EXEC;
         end
         cbhd_pkg::CBHD_DONE: begin
            s_nxt.done = 1'b1;
            s_nxt.busy = 1'b0;
            s_nxt.st = cbhd_pkg::CBHD_IDLE;
         end
         default: s_nxt.st = cbhd_pkg::CBHD_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{st: cbhd_pkg::CBHD_IDLE, act: cbhd_pkg::CBHD_ACT_NONE,
                  target_status: `CBHD_TS_GOOD, adapter_status: `CBHD_HS_OK,
                  default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Register-driven outputs
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         allow_disconnect <= 1'b0;
         dir_in <= 1'b0;
         dir_out <= 1'b0;
      end else begin
         allow_disconnect <= disc_enabled & ~s_nxt.hold_conn;
         dir_in <= s_nxt.dir_in & ~s_nxt.dir_out;
         dir_out <= s_nxt.dir_out & ~s_nxt.dir_in;
      end
   end

   assign busy = s_r.busy;
   assign exec_start = s_r.exec_start;
   assign exec_action = s_r.act;
   assign residual_mode = s_r.residual;
   assign dev_id = s_r.dev_id;
   assign lun = s_r.lun;
   assign no_xfer = s_r.no_xfer;
   assign cdb_len = s_r.cdb_len;
   assign done = s_r.done;
   assign status_index = s_r.status_index;
   assign adapter_status = s_r.adapter_status;
   assign target_status = s_r.target_status;

   // Checks
   sequence s_bad_op;
      hdr_valid && s_r.st == cbhd_pkg::CBHD_IDLE && !legacy_rst &&
         !hdr_byte0[`CBHD_B0_RST] && op > `CBHD_OP_SG_RES;
   endsequence

   AST_BAD_OP: assert property (@(posedge clock) disable iff (!rst_n)
      s_bad_op |=> ##1 (done && adapter_status == `CBHD_HS_BAD_OP))
      else $error("invalid opcode not flagged 16h");

   AST_TGT_DIR: assert property (@(posedge clock) disable iff (!rst_n)
      (hdr_valid && s_r.st == cbhd_pkg::CBHD_IDLE && hdr_byte0 == 8'h01 &&
       hdr_byte1[3] == hdr_byte1[4]) |=> ##1 (done && adapter_status == `CBHD_HS_BAD_PARAM))
      else $error("bad target direction not flagged 18h");

   AST_TGT_OFF: assert property (@(posedge clock) disable iff (!rst_n)
      (hdr_valid && s_r.st == cbhd_pkg::CBHD_IDLE && hdr_byte0 == 8'h01 && !target_mode_en)
      |=> !exec_start ##1 (done && adapter_status == `CBHD_HS_BAD_PARAM))
      else $error("target block without target mode not flagged");

   AST_LEGACY: assert property (@(posedge clock) disable iff (!rst_n)
      (hdr_valid && s_r.st == cbhd_pkg::CBHD_IDLE && legacy_rst)
      |=> (exec_start && exec_action == cbhd_pkg::CBHD_ACT_ABORT_RST))
      else $error("legacy reset not dispatched");

   AST_DEVRST: assert property (@(posedge clock) disable iff (!rst_n)
      (hdr_valid && s_r.st == cbhd_pkg::CBHD_IDLE && hdr_byte0[7] && !legacy_rst)
      |=> (exec_start && exec_action == cbhd_pkg::CBHD_ACT_DEVRST))
      else $error("device reset flag not dispatched");

   AST_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
      (hdr_valid && s_r.st == cbhd_pkg::CBHD_IDLE)
      |=> (dev_id == $past(hdr_byte1[7:5]) && lun == $past(hdr_byte1[2:0]) &&
           cdb_len == $past(hdr_byte2)))
      else $error("address or length not latched");

   AST_NO_RETRY: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.st == cbhd_pkg::CBHD_EXEC && exec_done && exec_busy && s_r.no_retry)
      |=> ##1 (done && target_status == $past(exec_tstatus, 2)))
      else $error("busy not reported when retry suppressed");

   AST_RETRY_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.st == cbhd_pkg::CBHD_EXEC && exec_done && exec_busy && !s_r.no_retry)
      |=> (s_r.st == cbhd_pkg::CBHD_WAIT && !exec_start)[*3])
      else $error("busy retry did not wait");

   AST_OVERRUN: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.st == cbhd_pkg::CBHD_EXEC && exec_done && !exec_busy && exec_overrun)
      |=> ##1 (done && adapter_status ==
               (s_r.len_check ? `CBHD_HS_OVERRUN : `CBHD_HS_OK)))
      else $error("overrun status wrong");

   // Helper terms for the dispatch checks
   logic take_now;
   logic clean_op;
   assign take_now = hdr_valid && s_r.st == cbhd_pkg::CBHD_IDLE;
   // Opcode in range; reset flags and reserved bits excluded
   assign clean_op = take_now && !legacy_rst && !hdr_byte0[`CBHD_B0_RST] &&
      hdr_byte0[4:3] == 2'h0 && op <= `CBHD_OP_SG_RES;

   // Initiator-side take, shared by several checks
   sequence s_init_take;
      clean_op && op != `CBHD_OP_TGT;
   endsequence

   // Valid initiator codes always start the executor
   AST_VALID_OP: assert property (@(posedge clock) disable iff (!rst_n)
      s_init_take |=> (exec_start && busy))
      else $error("valid opcode not started");

   // Plain initiator codes dispatch a plain initiator action
   AST_INIT_ACT: assert property (@(posedge clock) disable iff (!rst_n)
      (clean_op && (op == `CBHD_OP_INIT || op == `CBHD_OP_INIT_RES))
      |=> exec_action == cbhd_pkg::CBHD_ACT_INIT)
      else $error("initiator action wrong");

   // Segment-list codes dispatch the scatter/gather action
   AST_SG_ACT: assert property (@(posedge clock) disable iff (!rst_n)
      (clean_op && (op == `CBHD_OP_INIT_SG || op == `CBHD_OP_SG_RES))
      |=> exec_action == cbhd_pkg::CBHD_ACT_SG)
      else $error("scatter/gather action wrong");

   // Residual codes raise residual mode
   AST_RESIDUAL: assert property (@(posedge clock) disable iff (!rst_n)
      (clean_op && (op == `CBHD_OP_INIT_RES || op == `CBHD_OP_SG_RES))
      |=> residual_mode)
      else $error("residual mode missing");

   // Enabled target block with one direction bit is dispatched
   AST_TGT_START: assert property (@(posedge clock) disable iff (!rst_n)
      (clean_op && op == `CBHD_OP_TGT && target_mode_en && hdr_byte1[3] != hdr_byte1[4])
      |=> (exec_start && exec_action == cbhd_pkg::CBHD_ACT_TGT))
      else $error("target block not dispatched");

   // Both direction bits on an initiator block suppress the transfer
   AST_NO_XFER: assert property (@(posedge clock) disable iff (!rst_n)
      s_init_take ##0 (hdr_byte1[3] && hdr_byte1[4]) |=> no_xfer)
      else $error("no-transfer not flagged");

   // Direction outputs are registered from the next-state fields, so they change on the same edge as the latched fields
   AST_DIR_IN: assert property (@(posedge clock) disable iff (!rst_n)
      s_init_take ##0 (hdr_byte1[3] && !hdr_byte1[4]) |=> ##1 (dir_in && !dir_out))
      else $error("inbound direction wrong");

   // Hold flag keeps the target connected for this block
   AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      s_init_take ##0 hdr_byte0[`CBHD_B0_HOLD] |=> ##1 !allow_disconnect)
      else $error("hold flag ignored");

   // Start is a single-cycle strobe, also on a retry
   AST_START_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
      exec_start |=> !exec_start)
      else $error("start longer than one cycle");

   // Completion frees the decoder and names the status byte
   AST_DONE_IDX: assert property (@(posedge clock) disable iff (!rst_n)
      done |-> (!busy && status_index == 8'h0E))
      else $error("completion index or busy wrong");

   // Latched fields hold while a block is in flight
   AST_HOLD_FIELDS: assert property (@(posedge clock) disable iff (!rst_n)
      busy |=> ($stable(dev_id) && $stable(lun) && $stable(cdb_len)))
      else $error("fields changed while busy");

   // End of the retry wait restarts the command two cycles later
   AST_WAIT_END: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.st == cbhd_pkg::CBHD_WAIT && s_r.wait_cnt == 32'h0)
      |=> !exec_start ##1 exec_start)
      else $error("retry not restarted after wait");

   // Without length checking a run-over completes cleanly
   AST_NO_CHECK: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.st == cbhd_pkg::CBHD_EXEC && exec_done && !exec_busy && !s_r.len_check)
      |=> ##1 (done && adapter_status == `CBHD_HS_OK))
      else $error("unchecked transfer reported an error");

   // Idle with nothing offered stays quiet
   AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.st == cbhd_pkg::CBHD_IDLE && !hdr_valid) |=> (!exec_start && !busy))
      else $error("activity without a header");

endmodule

// ---- test/cbhd_exec_model.sv ----
`timescale 1ns/1ns
// Stand-in for the command executor beyond the decoder
module cbhd_exec_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic exec_start,
   input wire logic done,
   input wire logic [3:0] lat,
   input wire logic [1:0] busy_n,
   input wire logic ovr,
   input wire logic med,
   input wire logic [7:0] tst,
   output logic exec_done,
   output logic exec_busy,
   output logic exec_overrun,
   output logic exec_media,
   output logic [7:0] exec_tstatus
);
   logic run_r;
   logic tog_r;
   logic [3:0] cnt_r;
   logic [1:0] given_r;
   logic bsy;
   // Busy answers until the asked number has been given
   assign bsy = given_r < busy_n;
   // Results mean nothing without exec_done, so they toggle meanwhile
   assign exec_busy = exec_done ? bsy : tog_r;
   assign exec_overrun = exec_done ? ovr : tog_r;
   assign exec_media = exec_done ? med : ~tog_r;
   assign exec_tstatus = exec_done ? (bsy ? 8'h08 : tst) : {8{tog_r}};
   // Attempt timer; busy tally cleared once the block completes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 1'h0;
         tog_r <= 1'h0;
         cnt_r <= 4'h0;
         given_r <= 2'h0;
         exec_done <= 1'h0;
      end else begin
         tog_r <= ~tog_r;
         exec_done <= 1'h0;
         if (done) given_r <= 2'h0;
         // Tally after the decoder has sampled this attempt's answer
         if (exec_done && bsy) given_r <= given_r + 2'h1;
         if (exec_start) begin
            run_r <= 1'h1;
            cnt_r <= lat;
         end else if (run_r && cnt_r == 4'h0) begin
            run_r <= 1'h0;
            exec_done <= 1'h1;
         end else if (run_r) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule

// ---- test/command_block_header_decoder_tb_top.sv ----
`timescale 1ns/1ns
module command_block_header_decoder_tb_top;
   logic clock;
   logic rst_n;
   logic hdr_valid;
   logic [7:0] hdr_byte0, hdr_byte1, hdr_byte2;
   logic target_mode_en, disc_enabled;
   logic exec_done, exec_busy, exec_overrun, exec_media;
   logic [7:0] exec_tstatus, cdb_len, status_index, adapter_status, target_status;
   logic busy, exec_start, allow_disconnect, residual_mode, dir_in, dir_out, no_xfer, done;
   logic [2:0] dev_id, lun;
   cbhd_pkg::cbhd_act_t exec_action;
   logic [3:0] m_lat;
   logic [1:0] m_busy;
   logic m_ovr, m_med;
   logic [7:0] m_tst;
   logic [7:0] bad [5] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h10};
   int num_errors = 0;
   int check_count = 0;

   cbhd_decoder #(.RETRY_CYCLES(5)) dut (.clock, .rst_n, .hdr_valid, .hdr_byte0,
      .hdr_byte1, .hdr_byte2, .target_mode_en, .disc_enabled, .exec_done, .exec_busy,
      .exec_overrun, .exec_media, .exec_tstatus, .busy, .exec_start, .exec_action,
      .allow_disconnect, .residual_mode, .dev_id, .lun, .dir_in, .dir_out, .no_xfer,
      .cdb_len, .done, .status_index, .adapter_status, .target_status);

   cbhd_exec_model model (.clock, .rst_n, .exec_start, .done, .lat(m_lat), .busy_n(m_busy),
      .ovr(m_ovr), .med(m_med), .tst(m_tst), .exec_done, .exec_busy, .exec_overrun,
      .exec_media, .exec_tstatus);

   // 50 MHz clock
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // One block: offer header, count starts, wait bounded for done
   task automatic blk(input string nm, input logic [7:0] b0, input logic [7:0] b1,
      input logic [7:0] b2, input logic [7:0] eas, input int est);
      int n;
      int k;
      n = 0;
      k = 0;
      @(posedge clock);
      hdr_byte0 <= b0;
      hdr_byte1 <= b1;
      hdr_byte2 <= b2;
      hdr_valid <= 1'h1;
      @(posedge clock);
      hdr_valid <= 1'h0;
      do begin
         @(negedge clock);
         if (exec_start === 1'h1) n++;
         k++;
      end while (done !== 1'h1 && k < 300);
      chk({nm, " done"}, done, 1);
      chk({nm, " status"}, adapter_status, eas);
      chk({nm, " index"}, status_index, 14);
      chk({nm, " starts"}, n, est);
      $display("test %s finished", nm);
      @(posedge clock);
   endtask

   function automatic logic [2:0] exp_act(input int op);
      case (op)
         1: return cbhd_pkg::CBHD_ACT_TGT;
         2, 4: return cbhd_pkg::CBHD_ACT_SG;
         default: return cbhd_pkg::CBHD_ACT_INIT;
      endcase
   endfunction

   // Hang guard, far beyond the expected run length
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      close_out;
   end

   // Test sequence
   initial begin
      rst_n = 1'h0;
      hdr_valid = 1'h0;
      hdr_byte0 = 8'h00;
      hdr_byte1 = 8'h00;
      hdr_byte2 = 8'h00;
      target_mode_en = 1'h1;
      disc_enabled = 1'h1;
      m_lat = 4'h0;
      m_busy = 2'h0;
      m_ovr = 1'h0;
      m_med = 1'h0;
      m_tst = 8'h00;
      repeat (2) @(posedge clock);
      rst_n <= 1'h1;
      for (int op = 0; op < 5; op++) begin
         m_lat <= 4'(op * 3);
         blk("opcode", 8'(op), 8'hA9, 8'(op + 6), 8'h00, 1);
         chk("action", exec_action, exp_act(op));
         chk("residual", residual_mode, op > 2);
         chk("ids", {dev_id, lun}, 6'h29);
         chk("cdb_len", cdb_len, op + 6);
         chk("dirs", {dir_in, dir_out, no_xfer}, 3'h4);
         chk("disc", allow_disconnect, 1);
      end
      target_mode_en <= 1'h0;
      blk("tgt off", 8'h01, 8'h08, 8'h06, 8'h18, 0);
      target_mode_en <= 1'h1;
      blk("tgt none", 8'h01, 8'h00, 8'h06, 8'h18, 0);
      blk("tgt both", 8'h01, 8'h18, 8'h06, 8'h18, 0);
      for (int i = 0; i < 5; i++) blk("bad op", bad[i], 8'h08, 8'h06, 8'h16, 0);
      blk("legacy", 8'h81, 8'hE0, 8'h06, 8'h00, 1);
      chk("legacy act", {exec_action, dev_id}, {cbhd_pkg::CBHD_ACT_ABORT_RST, 3'h7});
      blk("dev rst", 8'hE3, 8'h48, 8'h06, 8'h00, 1);
      chk("rst act", {exec_action, dev_id}, {cbhd_pkg::CBHD_ACT_DEVRST, 3'h2});
      m_busy <= 2'h2;
      blk("retry", 8'h00, 8'h08, 8'h06, 8'h00, 3);
      chk("tstat", target_status, 8'h00);
      m_busy <= 2'h1;
      blk("no retry", 8'h20, 8'h08, 8'h06, 8'h00, 1);
      chk("tstat", target_status, 8'h08);
      m_busy <= 2'h0;
      blk("hold", 8'h40, 8'h08, 8'h06, 8'h00, 1);
      chk("disc", allow_disconnect, 0);
      disc_enabled <= 1'h0;
      blk("no disc", 8'h00, 8'h08, 8'h06, 8'h00, 1);
      chk("disc", allow_disconnect, 0);
      m_ovr <= 1'h1;
      m_med <= 1'h1;
      blk("out ovr", 8'h00, 8'h10, 8'h06, 8'h12, 1);
      chk("dirs", {dir_in, dir_out, no_xfer}, 3'h2);
      blk("both ovr", 8'h00, 8'h18, 8'h06, 8'h12, 1);
      chk("dirs", {dir_in, dir_out, no_xfer}, 3'h1);
      blk("media", 8'h00, 8'h00, 8'h06, 8'h00, 1);
      close_out;
   end
endmodule
